// ===== include/adc_mode_pin_control_map.vh
`ifndef ADC_MODE_PIN_CONTROL_MAP_VH
`define ADC_MODE_PIN_CONTROL_MAP_VH

// Register byte addresses
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_INT_STATUS 8'h08
`define ADDR_INT_MASK 8'h0C

// Control register fields
`define CTRL_FS_LSB 0
`define CTRL_FS_MSB 8
`define CTRL_CAL_REQ 16
`define CTRL_RESET 9'h080

// Status register fields
`define ST_TRIM_RUN 0
`define ST_EXT_MODE 1
`define ST_DES_MODE 2
`define ST_WAIT_LONG 3
`define ST_RANGE_HI 4
`define ST_SERIAL_SEL 5

// Interrupt bits
`define INT_CAL_DONE 0
`define INT_MODE_CHG 1
`define INT_CAL_START 2
`define INT_WIDTH 3

// Three-level pin codes
`define LVL_LOW 2'b00
`define LVL_HIGH 2'b01
`define LVL_MID 2'b10

// Configuration pin indices
`define PIN_RANGE_ECE 0
`define PIN_DELAY_SEL 1

// Full-scale codes used in normal mode
`define FS_CODE_650 9'h000
`define FS_CODE_870 9'h1FF

// Calibration trigger low and high minimum, in input clock cycles
`define TRIG_MIN_CYCLES 7'd80

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ===== hw/tri_level_resolve.v
`timescale 1ns/1ps
`default_nettype none
`include "adc_mode_pin_control_map.vh"

// Pad probed once with a weak pull-up and once with a weak pull-down:
// both high means driven high, both low driven low, otherwise the pin
// follows the pull, so it floats or sits near half supply.
module tri_level_resolve (
   input wire clk_i,
   input wire sense_up_i,
   input wire sense_dn_i,
   output reg [1:0] level_o
);

   // No reset: straps are resolved all through reset, so the wait choice
   // and the mode outputs are right at the first edge after release
   always @(posedge clk_i) begin
      if (sense_up_i && sense_dn_i) begin
         level_o <= `LVL_HIGH;
      end else if (!sense_up_i && !sense_dn_i) begin
         level_o <= `LVL_LOW;
      end else begin
         level_o <= `LVL_MID;
      end
   end

endmodule // tri_level_resolve

`default_nettype wire

// ===== hw/adc_mode_pin_control.v
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "adc_mode_pin_control_map.vh"

module adc_mode_pin_control #(
   parameter [23:0] WAIT_SHORT_CYCLES = 24'h001000,
   parameter [23:0] WAIT_LONG_CYCLES = 24'h100000,
   parameter [23:0] CAL_RUN_CYCLES = 24'h002000
) (
   input wire clk_i,
   input wire reset_i,
   input wire [1:0] cfg_sense_up_i,
   input wire [1:0] cfg_sense_dn_i,
   input wire cal_trigger_i,
   input wire [7:0] analog_i_i,
   input wire [7:0] analog_q_i,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg trim_in_progress_o,
   output reg extended_ctrl_enable_o,
   output reg serial_port_select_o,
   output reg dual_edge_o,
   output reg [8:0] full_scale_code_o,
   output reg [7:0] sample_i_fall_o,
   output reg [7:0] sample_i_rise_o,
   output reg [7:0] sample_q_o,
   output reg irq_o
);

   localparam [1:0] ST_INIT = 2'd0;
   localparam [1:0] ST_WAIT = 2'd1;
   localparam [1:0] ST_IDLE = 2'd2;
   localparam [1:0] ST_CAL = 2'd3;

   function is_mid;
      input [1:0] lvl;
      begin
         is_mid = (lvl == `LVL_MID);
      end
   endfunction

   wire [1:0] lvl [0:1];
   reg [1:0] state_reg;
   reg [23:0] cnt_reg;
   reg [23:0] wait_lim_reg;
   reg wait_long_reg;
   reg [6:0] low_cnt_reg;
   reg [6:0] high_cnt_reg;
   reg trig_armed_reg;
   reg [8:0] fs_adj_reg;
   reg cal_req_reg;
   reg [`INT_WIDTH-1:0] int_status_reg;
   reg [`INT_WIDTH-1:0] int_mask_reg;
   reg [7:0] aw_addr_reg;
   reg aw_held_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg w_held_reg;
   wire ext_mode;
   wire des_mode;
   wire pin_start;
   wire cal_start;
   wire cal_done;
   wire do_write;
   reg [`INT_WIDTH-1:0] events;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_pin
         tri_level_resolve u_res (
            .clk_i(clk_i),
            .sense_up_i(cfg_sense_up_i[g]),
            .sense_dn_i(cfg_sense_dn_i[g]),
            .level_o(lvl[g])
         );
      end
   endgenerate

   assign ext_mode = is_mid(lvl[`PIN_RANGE_ECE]);
   assign des_mode = is_mid(lvl[`PIN_DELAY_SEL]);

   always @(posedge clk_i) begin
      if (reset_i) begin
         extended_ctrl_enable_o <= 1'b0;
         serial_port_select_o <= 1'b0;
         dual_edge_o <= 1'b0;
         full_scale_code_o <= `FS_CODE_650;
      end else begin
         extended_ctrl_enable_o <= ext_mode;
         dual_edge_o <= des_mode;
         // Delay pin acts as serial select in extended mode only
         serial_port_select_o <= ext_mode &&
            (lvl[`PIN_DELAY_SEL] == `LVL_HIGH);
         if (ext_mode) begin
            full_scale_code_o <= fs_adj_reg;
         end else if (lvl[`PIN_RANGE_ECE] == `LVL_HIGH) begin
            full_scale_code_o <= `FS_CODE_870;
         end else begin
            full_scale_code_o <= `FS_CODE_650;
         end
      end
   end

   always @(negedge clk_i) begin
      if (reset_i) begin
         sample_i_fall_o <= 8'h00;
         sample_q_o <= 8'h00;
      end else begin
         sample_i_fall_o <= analog_i_i;
         if (!dual_edge_o) begin
            sample_q_o <= analog_q_i;
         end
      end
   end

   // Second I sample on rising edge
   always @(posedge clk_i) begin
      if (reset_i) begin
         sample_i_rise_o <= 8'h00;
      end else if (dual_edge_o) begin
         sample_i_rise_o <= analog_i_i;
      end
   end

   assign pin_start = trig_armed_reg && cal_trigger_i &&
      (high_cnt_reg == `TRIG_MIN_CYCLES - 7'd1);
   always @(posedge clk_i) begin
      if (reset_i) begin
         low_cnt_reg <= 7'd0;
         high_cnt_reg <= 7'd0;
         trig_armed_reg <= 1'b0;
      end else if (!cal_trigger_i) begin
         high_cnt_reg <= 7'd0;
         if (low_cnt_reg != `TRIG_MIN_CYCLES) begin
            low_cnt_reg <= low_cnt_reg + 7'd1;
         end
         if (low_cnt_reg == `TRIG_MIN_CYCLES - 7'd1) begin
            trig_armed_reg <= 1'b1;
         end
      end else begin
         low_cnt_reg <= 7'd0;
         if (high_cnt_reg != `TRIG_MIN_CYCLES) begin
            high_cnt_reg <= high_cnt_reg + 7'd1;
         end
         if (pin_start) begin
            trig_armed_reg <= 1'b0;
         end
      end
   end

   assign cal_start = (state_reg == ST_IDLE) && (pin_start || cal_req_reg);
   assign cal_done = (state_reg == ST_CAL) && (cnt_reg == CAL_RUN_CYCLES);

   // Power-up wait then calibration; strap caught one cycle after reset
   always @(posedge clk_i) begin
      if (reset_i) begin
         state_reg <= ST_INIT;
         cnt_reg <= 24'h000000;
         wait_lim_reg <= 24'h000000;
         wait_long_reg <= 1'b0;
         trim_in_progress_o <= 1'b0;
      end else begin
         case (state_reg)
            ST_INIT: begin
               cnt_reg <= 24'h000000;
               state_reg <= ST_WAIT;
               if (!ext_mode && lvl[`PIN_DELAY_SEL] == `LVL_HIGH) begin
                  wait_lim_reg <= WAIT_LONG_CYCLES;
                  wait_long_reg <= 1'b1;
               end else begin
                  wait_lim_reg <= WAIT_SHORT_CYCLES;
                  wait_long_reg <= 1'b0;
               end
            end
            ST_WAIT: begin
               cnt_reg <= cnt_reg + 24'h000001;
               if (cnt_reg == wait_lim_reg) begin
                  cnt_reg <= 24'h000000;
                  state_reg <= ST_CAL;
                  trim_in_progress_o <= 1'b1;
               end
            end
            ST_IDLE: begin
               cnt_reg <= 24'h000000;
               if (cal_start) begin
                  state_reg <= ST_CAL;
                  trim_in_progress_o <= 1'b1;
               end
            end
            default: begin
               cnt_reg <= cnt_reg + 24'h000001;
               if (cal_done) begin
                  state_reg <= ST_IDLE;
                  trim_in_progress_o <= 1'b0;
               end
            end
         endcase
      end
   end

   // AXI4-Lite write: address and data taken in either order
   assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
   always @(posedge clk_i) begin
      if (reset_i) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end else begin
         s_axi_awready <= !aw_held_reg && !s_axi_awready &&
            !s_axi_bvalid && s_axi_awvalid;
         s_axi_wready <= !w_held_reg && !s_axi_wready &&
            !s_axi_bvalid && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr_reg == `ADDR_CTRL ||
                aw_addr_reg == `ADDR_STATUS ||
                aw_addr_reg == `ADDR_INT_STATUS ||
                aw_addr_reg == `ADDR_INT_MASK) begin
               s_axi_bresp <= `RESP_OKAY;
            end else begin
               s_axi_bresp <= `RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always @* begin
      events = {`INT_WIDTH{1'b0}};
      events[`INT_CAL_DONE] = cal_done;
      events[`INT_MODE_CHG] = ext_mode != extended_ctrl_enable_o;
      events[`INT_CAL_START] = cal_start;
   end

   // Register writes; a new event wins over a write-one clear
   always @(posedge clk_i) begin
      if (reset_i) begin
         fs_adj_reg <= `CTRL_RESET;
         cal_req_reg <= 1'b0;
         int_status_reg <= {`INT_WIDTH{1'b0}};
         int_mask_reg <= {`INT_WIDTH{1'b0}};
         irq_o <= 1'b0;
      end else begin
         if (cal_start) begin
            cal_req_reg <= 1'b0;
         end
         if (do_write && aw_addr_reg == `ADDR_CTRL) begin
            if (w_strb_reg[0]) begin
               fs_adj_reg[7:0] <= w_data_reg[7:0];
            end
            if (w_strb_reg[1]) begin
               fs_adj_reg[`CTRL_FS_MSB] <= w_data_reg[`CTRL_FS_MSB];
            end
            // Request waits for idle so it is never lost mid-calibration
            if (w_strb_reg[2] && w_data_reg[`CTRL_CAL_REQ]) begin
               cal_req_reg <= 1'b1;
            end
         end
         if (do_write && aw_addr_reg == `ADDR_INT_MASK && w_strb_reg[0]) begin
            int_mask_reg <= w_data_reg[`INT_WIDTH-1:0];
         end
         if (do_write && aw_addr_reg == `ADDR_INT_STATUS &&
             w_strb_reg[0]) begin
            int_status_reg <= (int_status_reg &
               ~w_data_reg[`INT_WIDTH-1:0]) | events;
         end else begin
            int_status_reg <= int_status_reg | events;
         end
         irq_o <= |(int_status_reg & int_mask_reg);
      end
   end

   // AXI4-Lite read: one cycle from address to data
   always @(posedge clk_i) begin
      if (reset_i) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            if (s_axi_araddr == `ADDR_CTRL) begin
               s_axi_rdata[`CTRL_FS_MSB:`CTRL_FS_LSB] <= fs_adj_reg;
               s_axi_rdata[`CTRL_CAL_REQ] <= cal_req_reg;
            end else if (s_axi_araddr == `ADDR_STATUS) begin
               s_axi_rdata[`ST_TRIM_RUN] <= trim_in_progress_o;
               s_axi_rdata[`ST_EXT_MODE] <= extended_ctrl_enable_o;
               s_axi_rdata[`ST_DES_MODE] <= dual_edge_o;
               s_axi_rdata[`ST_WAIT_LONG] <= wait_long_reg;
               s_axi_rdata[`ST_RANGE_HI] <=
                  lvl[`PIN_RANGE_ECE] == `LVL_HIGH;
               s_axi_rdata[`ST_SERIAL_SEL] <= serial_port_select_o;
            end else if (s_axi_araddr == `ADDR_INT_STATUS) begin
               s_axi_rdata[`INT_WIDTH-1:0] <= int_status_reg;
            end else if (s_axi_araddr == `ADDR_INT_MASK) begin
               s_axi_rdata[`INT_WIDTH-1:0] <= int_mask_reg;
            end else begin
               s_axi_rresp <= `RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // adc_mode_pin_control

`default_nettype wire

// ===== testbench/board_pins.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_mode_pin_control_map.vh"
module board_pins (
   input wire logic clk_i,
   input wire logic [1:0] range_lvl_i,
   input wire logic [1:0] delay_lvl_i,
   output logic [1:0] cfg_sense_up_o,
   output logic [1:0] cfg_sense_dn_o,
   output logic cal_trigger_o
);
   // An open pin follows the probing pull
   always_comb begin
      cfg_sense_up_o = {delay_lvl_i != `LVL_LOW, range_lvl_i != `LVL_LOW};
      cfg_sense_dn_o = {delay_lvl_i == `LVL_HIGH, range_lvl_i == `LVL_HIGH};
   end
   initial cal_trigger_o = 1'b0;
   task automatic fire(input int lo, input int hi);
      cal_trigger_o <= 1'b0;
      repeat (lo) @(posedge clk_i);
      cal_trigger_o <= 1'b1;
      repeat (hi) @(posedge clk_i);
      cal_trigger_o <= 1'b0;
   endtask
endmodule // board_pins
`default_nettype wire

// ===== testbench/adc_mode_pin_control_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_mode_pin_control_map.vh"
module adc_mode_pin_control_monitor #(
   parameter [23:0] CAL_RUN_CYCLES = 24'h002000
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [1:0] cfg_sense_up_i,
   input wire logic [1:0] cfg_sense_dn_i,
   input wire logic [7:0] analog_i_i,
   input wire logic [7:0] analog_q_i,
   input wire logic trim_in_progress_o,
   input wire logic extended_ctrl_enable_o,
   input wire logic serial_port_select_o,
   input wire logic dual_edge_o,
   input wire logic [8:0] full_scale_code_o,
   input wire logic [7:0] sample_i_fall_o,
   input wire logic [7:0] sample_i_rise_o,
   input wire logic [7:0] sample_q_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   logic [7:0] fall_seen;
   logic [7:0] q_seen;
   logic [24:0] run_cnt;
   always @(negedge clk_i) fall_seen <= analog_i_i;
   always @(negedge clk_i) q_seen <= analog_q_i;
   always @(posedge clk_i) begin
      if (reset_i || !trim_in_progress_o) run_cnt <= '0;
      else run_cnt <= run_cnt + 25'd1;
   end
   property p_ext_on;
      (cfg_sense_up_i[0] && !cfg_sense_dn_i[0]) [*3] |-> extended_ctrl_enable_o;
   endproperty
   a_ext_on: assert property (p_ext_on) else $error("ext mode off");
   property p_ext_off;
      (cfg_sense_up_i[0] == cfg_sense_dn_i[0]) [*3]
         |-> !extended_ctrl_enable_o && !serial_port_select_o;
   endproperty
   a_ext_off: assert property (p_ext_off) else $error("ext mode on");
   property p_ser;
      serial_port_select_o |-> extended_ctrl_enable_o && $past(cfg_sense_dn_i[1], 2);
   endproperty
   a_ser: assert property (p_ser) else $error("bad serial select");
   property p_des;
      (cfg_sense_up_i[1] != cfg_sense_dn_i[1]) [*3] |-> dual_edge_o;
   endproperty
   a_des: assert property (p_des) else $error("dual edge off");
   property p_fs_hi;
      (cfg_sense_up_i[0] && cfg_sense_dn_i[0]) [*3] |-> full_scale_code_o == `FS_CODE_870;
   endproperty
   a_fs_hi: assert property (p_fs_hi) else $error("fs high wrong");
   property p_fs_lo;
      (!cfg_sense_up_i[0] && !cfg_sense_dn_i[0]) [*3] |-> full_scale_code_o == `FS_CODE_650;
   endproperty
   a_fs_lo: assert property (p_fs_lo) else $error("fs low wrong");
   property p_fall;
      !$past(reset_i) |-> sample_i_fall_o == fall_seen;
   endproperty
   a_fall: assert property (p_fall) else $error("fall sample wrong");
   property p_qcap;
      !$past(reset_i) && !dual_edge_o |-> sample_q_o == q_seen;
   endproperty
   a_qcap: assert property (p_qcap) else $error("Q sample wrong");
   property p_rise;
      dual_edge_o |=> sample_i_rise_o == $past(analog_i_i);
   endproperty
   a_rise: assert property (p_rise) else $error("rise sample wrong");
   property p_qfrz;
      $past(dual_edge_o) && dual_edge_o |-> $stable(sample_q_o);
   endproperty
   a_qfrz: assert property (p_qfrz) else $error("Q not ignored");
   property p_run;
      $fell(trim_in_progress_o) |-> run_cnt == CAL_RUN_CYCLES + 25'd1;
   endproperty
   a_run: assert property (p_run) else $error("run length wrong");
   c_run: cover property ($rose(trim_in_progress_o));
   c_des: cover property (dual_edge_o);
   c_ser: cover property (serial_port_select_o);
endmodule // adc_mode_pin_control_monitor
bind adc_mode_pin_control adc_mode_pin_control_monitor #(
   .CAL_RUN_CYCLES(CAL_RUN_CYCLES)
) u_monitor (
   .clk_i(clk_i), .reset_i(reset_i), .cfg_sense_up_i(cfg_sense_up_i),
   .cfg_sense_dn_i(cfg_sense_dn_i), .analog_i_i(analog_i_i),
   .analog_q_i(analog_q_i),
   .trim_in_progress_o(trim_in_progress_o),
   .extended_ctrl_enable_o(extended_ctrl_enable_o),
   .serial_port_select_o(serial_port_select_o), .dual_edge_o(dual_edge_o),
   .full_scale_code_o(full_scale_code_o), .sample_i_fall_o(sample_i_fall_o),
   .sample_i_rise_o(sample_i_rise_o), .sample_q_o(sample_q_o)
);
`default_nettype wire

// ===== testbench/test_adc_mode_pin_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_mode_pin_control_map.vh"
module test_adc_mode_pin_control;
   // Short counts keep the run small; windows below derive from them
   localparam [23:0] WS = 24'd8, WL = 24'd20, CR = 24'd10;
   logic clk_i = 0, reset_i = 1, cal, awvalid = 0, wvalid = 0;
   logic bready = 0, arvalid = 0, rready = 0;
   logic [1:0] rlvl = `LVL_HIGH, dlvl = `LVL_HIGH, up, dn;
   logic [7:0] ai = 0, aq = 0, awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic [3:0] wstrb = 0;
   logic [65:0] q;
   logic [65:0] expq[$];
   logic [1:0] bexpq[$];
   wire awready, wready, bvalid, arready, rvalid, trim, ext, ser, des, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [8:0] fs;
   wire [7:0] s_fall, s_rise, s_q;
   int n_errors = 0, num_checks = 0, cyc = 0, seed = 59, n;
   board_pins u_board_pins (.clk_i(clk_i), .range_lvl_i(rlvl),
      .delay_lvl_i(dlvl), .cfg_sense_up_o(up), .cfg_sense_dn_o(dn),
      .cal_trigger_o(cal));
   adc_mode_pin_control #(.WAIT_SHORT_CYCLES(WS), .WAIT_LONG_CYCLES(WL),
      .CAL_RUN_CYCLES(CR)) u_adc_mode_pin_control (.clk_i(clk_i),
      .reset_i(reset_i), .cfg_sense_up_i(up), .cfg_sense_dn_i(dn),
      .cal_trigger_i(cal), .analog_i_i(ai), .analog_q_i(aq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trim_in_progress_o(trim),
      .extended_ctrl_enable_o(ext), .serial_port_select_o(ser),
      .dual_edge_o(des), .full_scale_code_o(fs), .sample_i_fall_o(s_fall),
      .sample_i_rise_o(s_rise), .sample_q_o(s_q), .irq_o(irq));
   always #50 clk_i = ~clk_i;
   task automatic finish_test();
      if (n_errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      ai <= 8'($random(seed));
      aq <= 8'($random(seed));
      if (cyc == 20000) begin
         n_errors++;
         finish_test();
      end
      if (bvalid && bready) chk("bresp", bexpq.pop_front(), bresp);
      if (rvalid && rready) begin
         q = expq.pop_front();
         chk("rdata", q[31:0], rdata & q[65:34]);
         chk("rresp", q[33:32], rresp);
      end
   end
   task automatic wr(input [7:0] a, input [31:0] d, input [1:0] er);
      int t = 0;
      @(posedge clk_i);
      bexpq.push_back(er);
      awaddr <= a; wdata <= d; wstrb <= 4'hF;
      awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge clk_i);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         t++;
      end while (!bvalid && t < 50);
      bready <= 0;
   endtask
   task automatic rd(input [7:0] a, input [31:0] e, input [31:0] m, input [1:0] er);
      int t = 0;
      @(posedge clk_i);
      expq.push_back({m, er, e});
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge clk_i);
         if (arready) arvalid <= 0;
         t++;
      end while (!rvalid && t < 50);
      rready <= 0;
   endtask
   task automatic boot(input [1:0] r, input [1:0] d);
      @(posedge clk_i);
      reset_i <= 1; rlvl <= r; dlvl <= d;
      repeat (19) @(posedge clk_i);
      reset_i <= 0;
   endtask
   task automatic wait_on(input logic v, input int lim);
      n = 0;
      while (trim !== v && n < lim) begin
         @(posedge clk_i);
         n++;
      end
   endtask
   task automatic wait_cal(input int lo);
      wait_on(1'b1, 100);
      chk("trim_start", 1, n >= lo && n <= lo + 6);
      wait_on(1'b0, 100);
      chk("trim_len", CR + 1, n);
   endtask
   task automatic wait_irq(input logic v);
      for (int i = 0; i < 10 && irq !== v; i++) @(posedge clk_i);
      chk("irq", v, irq);
   endtask
   initial begin
      boot(`LVL_HIGH, `LVL_HIGH);
      wait_cal(WL);
      chk("fs_hi", `FS_CODE_870, fs);
      rd(`ADDR_STATUS, 32'h18, 32'h3F, `RESP_OKAY);
      boot(`LVL_LOW, `LVL_LOW);
      wait_cal(WS);
      chk("fs_lo", `FS_CODE_650, fs);
      chk("modes", 3'b000, {ext, ser, des});
      boot(`LVL_MID, `LVL_HIGH);
      wait_cal(WS);
      chk("modes", 3'b110, {ext, ser, des});
      rd(`ADDR_STATUS, 32'h22, 32'h3F, `RESP_OKAY);
      rd(`ADDR_CTRL, 32'h080, 32'h1FF, `RESP_OKAY);
      wr(`ADDR_CTRL, 32'h155, `RESP_OKAY);
      for (int i = 0; i < 10 && fs !== 9'h155; i++) @(posedge clk_i);
      chk("fs_ext", 9'h155, fs);
      wr(`ADDR_CTRL, 32'h00010155, `RESP_OKAY);
      wait_cal(0);
      wr(8'h14, 32'h1, `RESP_SLVERR);
      rd(8'h10, 32'h0, 32'hFFFFFFFF, `RESP_SLVERR);
      boot(`LVL_HIGH, `LVL_MID);
      wait_cal(WS);
      chk("modes", 3'b001, {ext, ser, des});
      wr(`ADDR_INT_STATUS, 32'h7, `RESP_OKAY);
      wr(`ADDR_INT_MASK, 32'h0, `RESP_OKAY);
      u_board_pins.fire(80, 79);
      wait_on(1'b1, 100);
      chk("short_trigger", 100, n);
      u_board_pins.fire(80, 80);
      wait_on(1'b1, 3);
      chk("trigger_start", 1, trim);
      wait_on(1'b0, 100);
      wait_irq(1'b0);
      rd(`ADDR_INT_STATUS, 32'h5, 32'h5, `RESP_OKAY);
      wr(`ADDR_INT_MASK, 32'h1, `RESP_OKAY);
      wait_irq(1'b1);
      wr(`ADDR_INT_STATUS, 32'h1, `RESP_OKAY);
      wait_irq(1'b0);
      rd(`ADDR_INT_STATUS, 32'h4, 32'h5, `RESP_OKAY);
      finish_test();
   end
endmodule // test_adc_mode_pin_control
`default_nettype wire
